/* File: host_model.sv */
// host master model issuing object reads and writes
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic        clk,
    output logic             obj_wr,
    output logic             obj_rd,
    output logic [15:0]      obj_index,
    output logic [31:0]      obj_wdata,
    input  wire logic [31:0] obj_rdata,
    input  wire logic        obj_ack,
    input  wire logic        obj_err
);
    // idle bus at time zero
    initial begin
        obj_wr    = 1'b0;
        obj_rd    = 1'b0;
        obj_index = 16'h0000;
        obj_wdata = 32'h0000_0000;
    end
    // one access: strobe for one edge, answer taken the cycle after
    task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        obj_wr    <= w;
        obj_rd    <= !w;
        obj_index <= i;
        obj_wdata <= d; // callers never pass reserved option codes
        @(posedge clk);
        obj_wr    <= 1'b0;
        obj_rd    <= 1'b0;
        obj_wdata <= ~d; // released data must not look stale
        #1;
        r = obj_ack ? obj_rdata : 32'hx; // missing ack poisons the result
        e = obj_ack ? obj_err : 1'bx;
    endtask : acc
endmodule : host_model
`default_nettype wire

/* File: pos_opt_pkg.sv */
// constants, field layouts and types shared by the positioning option block
package pos_opt_pkg;

    // register indices (object numbers)
    localparam logic [15:0] IDX_OPTION_WORD = 16'h60F2;
    localparam logic [15:0] IDX_FOLLOW_ERR  = 16'h60F4;
    localparam logic [15:0] IDX_MAX_SLIP    = 16'h60F8;
    localparam logic [15:0] IDX_CORRECTION  = 16'h60FA;
    localparam logic [15:0] IDX_DEMAND_INC  = 16'h60FC;

    // reset values and the slip monitoring off value
    localparam logic [15:0] RST_OPTION_WORD = 16'h0001;
    localparam logic [31:0] RST_MAX_SLIP    = 32'h0000_0190;
    localparam logic [31:0] RST_MONITOR     = 32'h0000_0000;
    localparam logic [31:0] SLIP_OFF_VALUE  = 32'h7FFF_FFFF;

    // option word field positions
    localparam int REL_LSB = 0;
    localparam int RLS_LSB = 4;
    localparam int ROT_LSB = 6;

    // mask of option bits that are stored
    localparam logic [15:0] OPTION_MASK = 16'h00F3;

    // controlword / statusword bit positions
    localparam int CW_NEW_SETPOINT = 4;
    localparam int CW_RELATIVE     = 6;
    localparam int SW_SETPOINT_ACK = 12;
    localparam int SW_SLIP_ERROR   = 13;

    // slip qualification counter width
    localparam int QUAL_W = 16;

    // two-bit field codes
    typedef enum logic [1:0] {
        REL_PREV_TARGET = 2'h0,
        REL_RAMP_OUTPUT = 2'h1,
        REL_ACTUAL_POS  = 2'h2,
        REL_RESERVED    = 2'h3
    } rel_ref_e;

    typedef enum logic [1:0] {
        RLS_HOST    = 2'h0,
        RLS_ON_DONE = 2'h1,
        RLS_ASAP    = 2'h2,
        RLS_RSVD    = 2'h3
    } release_e;

    typedef enum logic [1:0] {
        ROT_LINEAR   = 2'h0,
        ROT_NEG_ONLY = 2'h1,
        ROT_POS_ONLY = 2'h2,
        ROT_SHORTEST = 2'h3
    } rot_dir_e;

    // setpoint handshake states, gray from IDLE through MOVE to CLEAR
    typedef enum logic [1:0] {
        HS_IDLE  = 2'b00,
        HS_MOVE  = 2'b01,
        HS_CLEAR = 2'b11
    } hs_state_e;

endpackage : pos_opt_pkg

/* File: positioning_option_slip_monitor.sv */
// positioning option decode, setpoint release, rotary direction and monitors
//
// How it works
// - sixteen-bit option word, preset 0001, masked
// - bits 1..0 pick relative reference base
// - code 00 adds to previous target
// - code 01 adds to ramp output
// - code 10 adds to actual position
// - device clears new setpoint, then acknowledge
// - code 01 releases when target reached
// - code 10 releases immediately; 00 host
// - rotary 00 wraps at range limits
// - rotary 01 moves only negative
// - rotary 10 moves only positive
// - rotary 11 takes shortest path
// - following error read-only, resets zero
// - velocity mode excessive deviation sets bit 13
// - flag only after qualification time passes
// - limit 7FFFFFFF disables slip monitoring
// - slip limit signed, symmetric, preset 190
// - configured reaction logs error history entry
// - control effort exposed read-only
// - position demand increments exposed read-only
`timescale 1ns/10ps
`default_nettype none
module positioning_option_slip_monitor (
    input  wire logic                           clk,
    input  wire logic                           arst_n,
    input  wire logic                           en,
    // object access
    input  wire logic                           obj_wr,
    input  wire logic                           obj_rd,
    input  wire logic [15:0]                    obj_index,
    input  wire logic [31:0]                    obj_wdata,
    output logic [31:0]                         obj_rdata,
    output logic                                obj_ack,
    output logic                                obj_err,
    // controlword in, device-modified controlword and status out
    input  wire logic [15:0]                    ctrl_in,
    input  wire logic                           ctrl_in_wr,
    output logic [15:0]                         ctrl_word,
    output logic                                sw_setpoint_ack,
    output logic                                sw_slip_error,
    // motion inputs
    input  wire logic                           move_start,
    input  wire logic                           target_reached,
    input  wire logic signed [31:0]             target_in,
    input  wire logic signed [31:0]             ramp_output,
    input  wire logic signed [31:0]             actual_pos,
    input  wire logic signed [31:0]             range_min,
    input  wire logic signed [31:0]             range_max,
    input  wire logic signed [31:0]             following_error,
    input  wire logic signed [31:0]             control_effort,
    input  wire logic signed [31:0]             demand_increments,
    // velocity supervision inputs
    input  wire logic                           velocity_mode,
    input  wire logic signed [31:0]             actual_speed,
    input  wire logic signed [31:0]             set_speed,
    input  wire logic [pos_opt_pkg::QUAL_W-1:0] qual_cycles,
    input  wire logic                           slip_reaction_en,
    // resolved move and error history pulse
    output logic signed [31:0]                  move_target,
    output logic                                move_dir_neg,
    output logic                                move_via_limit,
    output logic                                move_valid,
    output logic                                history_log
);
    import pos_opt_pkg::*;

    typedef struct packed {
        logic [15:0]  opt;       // option word
        logic [31:0]  slip_lim;  // max slip limit
        logic [31:0]  ferr;      // following error snapshot
        logic [31:0]  effort;    // control effort snapshot
        logic [31:0]  demand;    // demand snapshot
        logic [31:0]  prev_tgt;  // last internal absolute target
        logic [31:0]  rdata;     // read answer
        logic         ack;       // access answered
        logic         err;       // unmapped index or write to a read-only monitor
        logic [15:0]  cw;        // controlword image
        logic         sp_ack;    // setpoint acknowledge
        hs_state_e    hs;        // release handshake
        logic [31:0]  tgt;       // resolved target
        logic         dneg;      // travel direction negative
        logic         via;       // passes through a limit
        logic         mvalid;    // resolved move pulse
        logic         slip;      // slip status
        logic         hlog;      // history entry pulse
    } top_s;

    top_s q, d;
    logic        slip_flag;       // qualified slip from monitor
    logic        slip_event;      // first detection pulse
    rel_ref_e    rel_sel;         // relative_reference_select
    release_e    rls_sel;         // setpoint_release_select
    rot_dir_e    rot_sel;         // rotary_direction_select
    logic [31:0] base;            // relative move base
    logic [31:0] abs_tgt;         // absolute target before wrap
    logic [31:0] span;            // range width
    logic [31:0] fwd;             // forward difference in range
    logic [31:0] wrapped;         // target after wrap

    // slippage supervision lives in its own module
    slip_monitor u_slip (
        .clk           (clk),
        .arst_n        (arst_n),
        .en            (en),
        .velocity_mode (velocity_mode),
        .actual_speed  (actual_speed),
        .set_speed     (set_speed),
        .max_slip      (q.slip_lim),
        .qual_cycles   (qual_cycles),
        .slip_flag     (slip_flag),
        .slip_event    (slip_event)
    );

    // field decode; reserved relative and release codes fall back to code 00
    always_comb begin
        rel_sel = rel_ref_e'(q.opt[REL_LSB +: 2]);
        rls_sel = release_e'(q.opt[RLS_LSB +: 2]);
        rot_sel = rot_dir_e'(q.opt[ROT_LSB +: 2]);
        if (rel_sel == REL_RESERVED) begin
            rel_sel = REL_PREV_TARGET;
        end
        if (rls_sel == RLS_RSVD) begin
            rls_sel = RLS_HOST;
        end
    end

    // relative base and target geometry
    always_comb begin
        unique case (rel_sel)
            REL_PREV_TARGET: base = q.prev_tgt;
            REL_RAMP_OUTPUT: base = ramp_output;
            REL_ACTUAL_POS:  base = actual_pos;
            default:         base = q.prev_tgt;
        endcase
        // relative only when controlword bit 6 is one
        abs_tgt = q.cw[CW_RELATIVE] ? (base + target_in) : target_in;
        span    = range_max - range_min;
        fwd     = abs_tgt - actual_pos;
        // wrap to the opposite end when beyond a limit; single wrap only
        if ($signed(abs_tgt) > range_max) begin
            wrapped = abs_tgt - span;
        end else if ($signed(abs_tgt) < range_min) begin
            wrapped = abs_tgt + span;
        end else begin
            wrapped = abs_tgt;
        end
    end

    // next state: object access, handshake, move resolution
    always_comb begin
        d        = q;
        d.ack    = 1'b0;
        d.err    = 1'b0;
        d.mvalid = 1'b0;
        d.hlog   = 1'b0;
        // monitor snapshots, read-only
        d.ferr   = following_error;
        d.effort = control_effort;
        d.demand = demand_increments;
        // host controlword writes
        if (ctrl_in_wr) begin
            d.cw = ctrl_in;
        end
        // register access; write wins over read when both asserted
        if (obj_wr) begin
            d.ack = 1'b1;
            unique case (obj_index)
                IDX_OPTION_WORD: d.opt = obj_wdata[15:0] & OPTION_MASK;
                IDX_MAX_SLIP:    d.slip_lim = obj_wdata;
                IDX_FOLLOW_ERR, IDX_CORRECTION, IDX_DEMAND_INC: d.err = 1'b1;
                default:         d.err = 1'b1;
            endcase
        end else if (obj_rd) begin
            d.ack = 1'b1;
            unique case (obj_index)
                IDX_OPTION_WORD: d.rdata = {16'h0000, q.opt};
                IDX_FOLLOW_ERR:  d.rdata = q.ferr;
                IDX_MAX_SLIP:    d.rdata = q.slip_lim;
                IDX_CORRECTION:  d.rdata = q.effort;
                IDX_DEMAND_INC:  d.rdata = q.demand;
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.err   = 1'b1;
                end
            endcase
        end
        // resolve a new move
        if (move_start) begin
            d.mvalid   = 1'b1;
            d.prev_tgt = wrapped;
            d.sp_ack   = 1'b1;
            d.via      = 1'b0;
            unique case (rot_sel)
                ROT_LINEAR: begin
                    d.tgt  = wrapped;
                    d.dneg = $signed(fwd) < 0;
                    d.via  = (wrapped != abs_tgt);
                end
                ROT_NEG_ONLY: begin
                    d.tgt  = wrapped;
                    d.dneg = 1'b1;
                    d.via  = $signed(wrapped) > actual_pos;
                end
                ROT_POS_ONLY: begin
                    d.tgt  = wrapped;
                    d.dneg = 1'b0;
                    d.via  = $signed(wrapped) < actual_pos;
                end
                ROT_SHORTEST: begin
                    // forward distance mod span below half a turn goes positive
                    d.tgt  = wrapped;
                    d.dneg = !((($signed(wrapped - actual_pos) >= 0) ?
                               (wrapped - actual_pos) : (wrapped - actual_pos + span))
                               < {1'b0, span[31:1]});
                    d.via  = 1'b0;
                end
                default: d.tgt = wrapped;
            endcase
        end
        // setpoint release handshake
        unique case (q.hs)
            HS_IDLE: begin
                if (move_start && rls_sel != RLS_HOST) begin
                    d.hs = (rls_sel == RLS_ASAP) ? HS_CLEAR : HS_MOVE;
                end
            end
            HS_MOVE: begin
                if (target_reached) begin
                    d.hs = HS_CLEAR;
                end
            end
            HS_CLEAR: begin
                // clear new setpoint first; acknowledge drops next cycle
                if (q.cw[CW_NEW_SETPOINT]) begin
                    d.cw[CW_NEW_SETPOINT] = 1'b0;
                end else begin
                    d.sp_ack = 1'b0;
                    d.hs     = HS_IDLE;
                end
            end
            default: d.hs = HS_IDLE;
        endcase
        // host driven mode: acknowledge follows the new setpoint bit
        if (rls_sel == RLS_HOST && !q.cw[CW_NEW_SETPOINT] && !move_start) begin
            d.sp_ack = 1'b0;
        end
        // slip status and error history
        d.slip = slip_flag;
        d.hlog = slip_event && slip_reaction_en;
    end

    // state register, frozen while enable is low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q          <= '0;
            q.opt      <= RST_OPTION_WORD;
            q.slip_lim <= RST_MAX_SLIP;
            q.ferr     <= RST_MONITOR;
            q.hs       <= HS_IDLE;
        end else if (en) begin
            q <= d;
        end
    end

    // outputs straight from flip-flops
    assign obj_rdata       = q.rdata;
    assign obj_ack         = q.ack;
    assign obj_err         = q.err;
    assign ctrl_word       = q.cw;
    assign sw_setpoint_ack = q.sp_ack;
    assign sw_slip_error   = q.slip;
    assign move_target     = q.tgt;
    assign move_dir_neg    = q.dneg;
    assign move_via_limit  = q.via;
    assign move_valid      = q.mvalid;
    assign history_log     = q.hlog;

endmodule : positioning_option_slip_monitor
`default_nettype wire

/* File: posm_chk.sv */
// assertion checker for the positioning option block ports
`timescale 1ns/10ps
`default_nettype none
module posm_chk (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        en,
    input wire logic        obj_wr,
    input wire logic        obj_rd,
    input wire logic [15:0] obj_index,
    input wire logic [31:0] obj_rdata,
    input wire logic        obj_ack,
    input wire logic        obj_err,
    input wire logic        move_start,
    input wire logic        move_valid,
    input wire logic        velocity_mode,
    input wire logic        slip_reaction_en,
    input wire logic        sw_slip_error,
    input wire logic        history_log
);
    import pos_opt_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic req;    // access taken at this edge
    logic ro_idx; // monitor index, never writable
    logic ok_idx; // any mapped index
    assign req    = en && (obj_wr || obj_rd);
    assign ro_idx = obj_index inside {IDX_FOLLOW_ERR, IDX_CORRECTION, IDX_DEMAND_INC};
    assign ok_idx = ro_idx || obj_index inside {IDX_OPTION_WORD, IDX_MAX_SLIP};
    a_ack_after_req: assert property (req |=> obj_ack)
        else $error("no ack one cycle after request");
    a_ack_has_cause: assert property (obj_ack |-> $past(req))
        else $error("ack without request");
    a_err_with_ack: assert property (obj_err |-> obj_ack)
        else $error("error flag without ack");
    a_ro_write_err: assert property (en && obj_wr && ro_idx |=> obj_err)
        else $error("write to monitor not refused");
    a_bad_rd_zero: assert property (en && obj_rd && !obj_wr && !ok_idx
        |=> obj_err && obj_rdata == 32'h0000_0000) else $error("unmapped read not refused");
    a_good_rd_ok: assert property (en && obj_rd && !obj_wr && ok_idx |=> !obj_err)
        else $error("mapped read refused");
    a_move_valid: assert property (en && move_start |=> move_valid)
        else $error("no resolved move after start");
    a_valid_cause: assert property (move_valid |-> $past(move_start))
        else $error("resolved move without start");
    a_slip_mode: assert property (!velocity_mode ##1 !velocity_mode |-> !sw_slip_error)
        else $error("slip flag outside velocity mode");
    a_hist_gate: assert property (history_log |-> $past(slip_reaction_en))
        else $error("history entry without reaction");
endmodule : posm_chk
bind positioning_option_slip_monitor posm_chk u_chk (
    .clk(clk), .arst_n(arst_n), .en(en), .obj_wr(obj_wr), .obj_rd(obj_rd),
    .obj_index(obj_index), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
    .move_start(move_start), .move_valid(move_valid), .velocity_mode(velocity_mode),
    .slip_reaction_en(slip_reaction_en), .sw_slip_error(sw_slip_error),
    .history_log(history_log)
);
`default_nettype wire

/* File: slip_monitor.sv */
// slippage monitor: deviation qualification over a configured time
`timescale 1ns/10ps
`default_nettype none
module slip_monitor (
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    input  wire logic                          en,
    input  wire logic                          velocity_mode,
    input  wire logic signed [31:0]            actual_speed,
    input  wire logic signed [31:0]            set_speed,
    input  wire logic signed [31:0]            max_slip,
    input  wire logic [pos_opt_pkg::QUAL_W-1:0] qual_cycles,
    output logic                               slip_flag,
    output logic                               slip_event
);
    import pos_opt_pkg::*;

    typedef struct packed {
        logic [QUAL_W-1:0] cnt;  // cycles of excessive deviation
        logic              flag; // qualified slip
        logic              evt;  // one-cycle detection pulse
    } slip_s;

    slip_s q, d;
    logic signed [32:0] diff;
    logic        [32:0] mag;
    logic        [32:0] lim;
    logic               excess;
    logic               active;

    // deviation magnitude, 33 bits so the subtraction cannot wrap
    always_comb begin
        diff   = 33'(actual_speed) - 33'(set_speed);
        mag    = diff[32] ? 33'(-diff) : 33'(diff);
        lim    = max_slip[31] ? 33'(-33'(max_slip)) : 33'(max_slip);
        active = velocity_mode && (max_slip != SLIP_OFF_VALUE);
        excess = active && (mag > lim);
    end

    // count persistence; flag only once the time is exceeded
    always_comb begin
        d     = q;
        d.evt = 1'b0;
        if (!excess) begin
            d.cnt  = '0;
            d.flag = 1'b0;
        end else if (q.cnt > qual_cycles) begin
            d.flag = 1'b1;
            d.evt  = !q.flag;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else if (en) begin
            q <= d;
        end
    end

    assign slip_flag  = q.flag;
    assign slip_event = q.evt;

endmodule : slip_monitor
`default_nettype wire

/* File: tb_positioning_option_slip_monitor.sv */
// testbench for the positioning option and slip monitor block
`timescale 1ns/10ps
`default_nettype none
module tb_positioning_option_slip_monitor;
    import pos_opt_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, en = 1'b1, ctrl_in_wr = 1'b0, move_start = 1'b0;
    logic target_reached = 1'b0, velocity_mode = 1'b0, slip_reaction_en = 1'b0;
    logic [15:0] ctrl_in = 16'h0000, obj_index, ctrl_word;
    logic [QUAL_W-1:0] qual_cycles = 16'h0003;
    logic signed [31:0] target_in = 32'h0, ramp_output = 32'h2000, actual_pos = 32'h3000;
    logic signed [31:0] range_min = 32'hFFF0_0000, range_max = 32'h0010_0000;
    logic signed [31:0] actual_speed = 32'h3E8, set_speed = 32'h3E8, move_target;
    logic signed [31:0] following_error = 32'h8000_1234, control_effort = 32'hFFFF_FF00;
    logic signed [31:0] demand_increments = 32'h0012_3456;
    logic [31:0] obj_wdata, obj_rdata;
    logic obj_wr, obj_rd, obj_ack, obj_err, sw_setpoint_ack, sw_slip_error, move_valid;
    logic move_dir_neg, move_via_limit, history_log, hist_seen = 1'b0;
    int n_errors = 0;
    int checked  = 0;
    host_model host (.clk(clk), .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_index(obj_index),
        .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));
    positioning_option_slip_monitor uut (.clk(clk), .arst_n(arst_n), .en(en),
        .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_index(obj_index), .obj_wdata(obj_wdata),
        .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err), .ctrl_in(ctrl_in),
        .ctrl_in_wr(ctrl_in_wr), .ctrl_word(ctrl_word), .sw_setpoint_ack(sw_setpoint_ack),
        .sw_slip_error(sw_slip_error), .move_start(move_start),
        .target_reached(target_reached), .target_in(target_in), .ramp_output(ramp_output),
        .actual_pos(actual_pos), .range_min(range_min), .range_max(range_max),
        .following_error(following_error), .control_effort(control_effort),
        .demand_increments(demand_increments), .velocity_mode(velocity_mode),
        .actual_speed(actual_speed), .set_speed(set_speed), .qual_cycles(qual_cycles),
        .slip_reaction_en(slip_reaction_en), .move_target(move_target),
        .move_dir_neg(move_dir_neg), .move_via_limit(move_via_limit),
        .move_valid(move_valid), .history_log(history_log));
    // 250 MHz clock
    always #2 clk = ~clk;
    // history pulses are short, so latch them
    always @(posedge clk) if (history_log === 1'b1) hist_seen <= 1'b1;
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task automatic rd(input logic [15:0] i, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        host.acc(1'b0, i, 32'h0, r, e);
        chk(r, x);
        chk(e, xe);
    endtask : rd
    task automatic wr(input logic [15:0] i, input logic [31:0] d, input logic xe);
        logic [31:0] r;
        logic e;
        host.acc(1'b1, i, d, r, e);
        chk(e, xe);
    endtask : wr
    // host controlword write pulse
    task automatic cw(input logic [15:0] v);
        @(posedge clk);
        ctrl_in    <= v;
        ctrl_in_wr <= 1'b1;
        @(posedge clk) ctrl_in_wr <= 1'b0;
    endtask : cw
    // new setpoint pulse, settled just after the taking edge
    task automatic mv(input logic [31:0] t);
        @(posedge clk);
        target_in  <= t;
        move_start <= 1'b1;
        @(posedge clk) move_start <= 1'b0;
        #1;
    endtask : mv
    task automatic mvchk(input logic [15:0] opt, input logic [31:0] t, input logic [31:0] x);
        wr(IDX_OPTION_WORD, {16'h0000, opt}, 1'b0);
        mv(t);
        chk(move_valid, 32'h1);
        chk(move_target, x);
    endtask : mvchk
    task automatic rot(input logic [15:0] opt, input logic [31:0] t, input logic [1:0] dv);
        mvchk(opt, t, t);
        chk({move_dir_neg, move_via_limit}, dv);
    endtask : rot
    task automatic t_regs;
        rd(IDX_OPTION_WORD, 32'h0000_0001, 1'b0);
        rd(IDX_MAX_SLIP, 32'h0000_0190, 1'b0);
        rd(IDX_FOLLOW_ERR, 32'h8000_1234, 1'b0);
        rd(IDX_CORRECTION, 32'hFFFF_FF00, 1'b0);
        rd(IDX_DEMAND_INC, 32'h0012_3456, 1'b0);
        wr(IDX_FOLLOW_ERR, 32'h0000_0005, 1'b1);
        wr(IDX_CORRECTION, 32'h0000_0005, 1'b1);
        wr(IDX_DEMAND_INC, 32'h0000_0005, 1'b1);
        rd(IDX_FOLLOW_ERR, 32'h8000_1234, 1'b0);
        rd(16'h60F3, 32'h0000_0000, 1'b1);
        wr(16'h60F6, 32'h0000_0001, 1'b1);
        wr(IDX_OPTION_WORD, 32'hFFFF_FF8C, 1'b0);
        rd(IDX_OPTION_WORD, 32'h0000_0080, 1'b0);
    endtask : t_regs
    task automatic t_moves;
        cw(16'h0040);
        mvchk(16'h0000, 32'h100, 32'h100);
        mvchk(16'h0000, 32'h10, 32'h110);
        mvchk(16'h0001, 32'h10, 32'h2010);
        mvchk(16'h0002, 32'h10, 32'h3010);
        cw(16'h0000);
        mvchk(16'h0002, 32'h10, 32'h10);
        mvchk(16'h0000, 32'h0011_0000, 32'hFFF1_0000);
        chk({move_dir_neg, move_via_limit}, 2'h1);
        rot(16'h0040, 32'h5000, 2'h3);
        rot(16'h0080, 32'h10, 2'h1);
        rot(16'h00C0, 32'h10, 2'h2);
        rot(16'h00C0, 32'h5000, 2'h0);
    endtask : t_moves
    task automatic t_release;
        int n;
        for (int c = 0; c < 3; c++) begin
            wr(IDX_OPTION_WORD, 32'(c << RLS_LSB), 1'b0);
            cw(16'h0010);
            mv(32'h20);
            chk(sw_setpoint_ack, 32'h1);
            n = 0;
            while (n < 8 && ctrl_word[4] === 1'b1) begin
                @(posedge clk) target_reached <= (c == 1 && n >= 3);
                n++;
                #1;
            end
            if (c == 0) begin
                chk(ctrl_word[4], 32'h1);
                cw(16'h0000);
            end else begin
                chk(32'(c == 2 ? n == 1 : n >= 5), 32'h1);
                chk(sw_setpoint_ack, 32'h1);
                @(posedge clk) target_reached <= 1'b0;
                #1 chk(sw_setpoint_ack, 32'h0);
            end
        end
    endtask : t_release
    task automatic t_slip;
        @(posedge clk);
        velocity_mode    <= 1'b1;
        slip_reaction_en <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            @(posedge clk) actual_speed <= s == 0 ? 32'h578 : s == 1 ? 32'h579 : 32'h257;
            repeat (4) @(posedge clk);
            #1 chk(sw_slip_error, 32'h0);
            repeat (3) @(posedge clk);
            #1 chk(sw_slip_error, 32'(s != 0));
            @(posedge clk) actual_speed <= 32'h3E8;
            repeat (2) @(posedge clk);
            #1 chk(sw_slip_error, 32'h0);
        end
        chk(hist_seen, 32'h1);
        wr(IDX_MAX_SLIP, SLIP_OFF_VALUE, 1'b0);
        rd(IDX_MAX_SLIP, SLIP_OFF_VALUE, 1'b0);
        @(posedge clk) actual_speed <= 32'h579;
        repeat (12) @(posedge clk);
        #1 chk(sw_slip_error, 32'h0);
    endtask : t_slip
    task automatic end_sim;
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // watchdog far beyond the expected run length
    initial begin
        #40000;
        n_errors++;
        end_sim;
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        t_regs;
        t_moves;
        t_release;
        t_slip;
        end_sim;
    end
endmodule : tb_positioning_option_slip_monitor
`default_nettype wire
